//--- pkg/dcdc_defs.svh
`ifndef DCDC_DEFS_SVH
`define DCDC_DEFS_SVH

`define DCDC_ADDR_W 12
`define DCDC_ADDR_CTRL 12'h091
`define DCDC_ADDR_STATUS 12'h092
`define DCDC_ADDR_GUARD 12'h093
`define DCDC_ADDR_COARSE 12'h094
`define DCDC_ADDR_FINE 12'h095
`define DCDC_ADDR_PHASE 12'h096
`define DCDC_ADDR_FILT 12'h097
`define DCDC_ADDR_READ 12'h098
`define DCDC_ADDR_RB_COARSE 12'h099
`define DCDC_ADDR_RB_FINE 12'h09a
`define DCDC_ADDR_RB_PHASE 12'h09b

`define DCDC_CTRL_RST 8'hf0
`define DCDC_CTRL_EN 0
`define DCDC_CTRL_MODE 2:1
`define DCDC_CTRL_DIR 4:3
`define DCDC_CTRL_SLOPE 5
`define DCDC_CTRL_SERR 6
`define DCDC_CTRL_TERR 7

`define DCDC_ST_LOCKED 0
`define DCDC_ST_LOST 1
`define DCDC_ST_FAIL 2

`define DCDC_GUARD_F 3:0
`define DCDC_COARSE_F 5:0
`define DCDC_PHASE_F 4:0
`define DCDC_BW_F 4:2
`define DCDC_WEIGHT_F 1:0
`define DCDC_READ_BIT 0

`define DCDC_COARSE_RST 6'h00
`define DCDC_FINE_RST 8'h80
`define DCDC_PHASE_RST 5'h08

`define DCDC_MODE_SRCH_TRK 2'h0
`define DCDC_MODE_TRK_ONLY 2'h1
`define DCDC_MODE_SRCH_ONLY 2'h2
`define DCDC_DIR_DOWN 2'h0
`define DCDC_DIR_UP 2'h1
`define DCDC_DIR_BOTH 2'h2

`define DCDC_POS_MAX 14'h3fff
`define DCDC_LOCK_TOL 5'h01
`define DCDC_LOST_TOL 5'h03
`define DCDC_CLK_NS 5
`define DCDC_SETTLE_NS 50

`endif

//--- pkg/dcdc_pkg.sv
package dcdc_pkg;
  typedef enum logic [2:0] {ST_OFF, ST_SEARCH, ST_TRACK, ST_HOLD, ST_FAIL} dcdc_state_e;
  typedef logic [13:0] dcdc_pos_t;
endpackage : dcdc_pkg

//--- src/dcdc_controller.sv
`timescale 1ns/100ps
`include "dcdc_defs.svh"
// Overview of operation
// - Controller disabled: delay lines follow static coarse and fine setpoints, no feedback.
// - Controller enabled: closed loop; mode 00 search+track, 01 track only, 10 search.
// - Search from initial point down, up or both ways, kept inside guard band.
// - Search error stops or retries; track error continues or restarts; both default 1.
// - Phase filtered by bandwidth, tracked at weighted speed, locked to target on chosen slope.
// - Six-bit coarse setpoint, reset 0, static delay and initial point.
// - Eight-bit fine setpoint, reset 0x80, static delay and initial point.
// - Status bit 0 read-only, set on lock, cleared at reset.
// - Status bit 2 read-only, set when lock cannot be acquired.
// - Status bit 1 set when an acquired lock is lost.
// - Rising edge of read request copies live coarse, fine and phase into readbacks.
// - Coarse readback read-only, bits 7:6 read zero.
// - Fine readback read-only, resets to zero.
// - Power-down bit high holds loop and digital clock generator powered down.
module dcdc_controller #(
  parameter int SETTLE_NS = `DCDC_SETTLE_NS
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [`DCDC_ADDR_W-1:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic loopPowerDown,
  input wire logic [4:0] phaseIn,
  output logic [5:0] coarseDelay,
  output logic [7:0] fineDelay,
  output logic dllPowerDown
);
  localparam int SETTLE_CYC = (SETTLE_NS + `DCDC_CLK_NS - 1) / `DCDC_CLK_NS;
  localparam logic [7:0] SETTLE_LD = 8'(SETTLE_CYC - 1);

  logic [7:0] ctrlR, fineSetR, fineSnapR, rdDataR, settleCntR, filtR;
  logic [5:0] coarseSetR, coarseSnapR;
  logic [4:0] phaseTgtR, phaseSnapR, phSync1R, phSync2R, prevPhaseR;
  logic [3:0] guardR;
  logic [2:0] bwR;
  logic [1:0] weightR;
  logic readReqR, lockedR, lostR, failR, dirUpR;
  dcdc_pkg::dcdc_pos_t posR;
  dcdc_pkg::dcdc_state_e stateR;

  logic loopRun, tick, inWin, outWin, slopeOk, atEdge, searchHit, searchErr, trackErr, trackLock;
  logic lockEvt, failEvt, snapEvt, lostClear, trackUp;
  logic [1:0] modeCode, dirCode;
  logic [4:0] phaseNow;
  dcdc_pkg::dcdc_pos_t initPos, loBound, hiBound;
  logic signed [8:0] filtDiff, filtStep;

  function automatic logic [4:0] phase_dist(input logic [4:0] a, input logic [4:0] b);
    return (a > b) ? a - b : b - a;
  endfunction : phase_dist

  // Saturating move; the search never walks past the guard band
  function automatic dcdc_pkg::dcdc_pos_t step_pos(input dcdc_pkg::dcdc_pos_t pos, input logic up,
      input dcdc_pkg::dcdc_pos_t amt, input dcdc_pkg::dcdc_pos_t lo, input dcdc_pkg::dcdc_pos_t hi);
    logic [14:0] sum;
    sum = {1'b0, pos} + {1'b0, amt};
    if (up)
      return (sum > {1'b0, hi}) ? hi : sum[13:0];
    else
      return ({1'b0, pos} < ({1'b0, lo} + {1'b0, amt})) ? lo : pos - amt;
  endfunction : step_pos

  assign loopRun = ctrlR[`DCDC_CTRL_EN] && !loopPowerDown;
  assign modeCode = ctrlR[`DCDC_CTRL_MODE];
  assign dirCode = ctrlR[`DCDC_CTRL_DIR];
  assign phaseNow = filtR[7:3];
  assign initPos = {coarseSetR, fineSetR};
  assign loBound = {2'b00, guardR, 8'h00};
  assign hiBound = `DCDC_POS_MAX - {2'b00, guardR, 8'h00};
  assign coarseDelay = posR[13:8];
  assign fineDelay = posR[7:0];
  assign dllPowerDown = loopPowerDown;
  assign regRdData = rdDataR;

  always_comb
  begin
    tick = loopRun && settleCntR == 8'h00 && (stateR == dcdc_pkg::ST_SEARCH || stateR == dcdc_pkg::ST_TRACK);
    inWin = phase_dist(phaseNow, phaseTgtR) <= `DCDC_LOCK_TOL;
    outWin = phase_dist(phaseNow, phaseTgtR) > `DCDC_LOST_TOL;
    slopeOk = (((phaseNow >= prevPhaseR) == dirUpR) == ctrlR[`DCDC_CTRL_SLOPE]);
    atEdge = dirUpR ? (posR >= hiBound) : (posR <= loBound);
    searchHit = tick && stateR == dcdc_pkg::ST_SEARCH && inWin && slopeOk;
    searchErr = tick && stateR == dcdc_pkg::ST_SEARCH && !searchHit && atEdge
      && !(dirCode == `DCDC_DIR_BOTH && dirUpR);
    trackErr = tick && stateR == dcdc_pkg::ST_TRACK && lockedR && outWin;
    trackLock = tick && stateR == dcdc_pkg::ST_TRACK && !lockedR && inWin;
    lockEvt = searchHit || trackLock;
    failEvt = searchErr && !ctrlR[`DCDC_CTRL_SERR];
    trackUp = (phaseNow < phaseTgtR) == ctrlR[`DCDC_CTRL_SLOPE];
    snapEvt = regWrEn && regAddr == `DCDC_ADDR_READ && regWrData[`DCDC_READ_BIT] && !readReqR;
    lostClear = regWrEn && regAddr == `DCDC_ADDR_STATUS && !regWrData[`DCDC_ST_LOST];
    filtDiff = $signed({1'b0, phSync2R, 3'b000}) - $signed({1'b0, filtR});
    filtStep = filtDiff >>> bwR;
  end

  // Software-written configuration
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ctrlR <= `DCDC_CTRL_RST;
      guardR <= 4'h0;
      coarseSetR <= `DCDC_COARSE_RST;
      fineSetR <= `DCDC_FINE_RST;
      phaseTgtR <= `DCDC_PHASE_RST;
      bwR <= 3'h0;
      weightR <= 2'h0;
      readReqR <= 1'b0;
    end
    else if (regWrEn)
    begin
      case (regAddr)
        `DCDC_ADDR_CTRL: ctrlR <= regWrData;
        `DCDC_ADDR_GUARD: guardR <= regWrData[`DCDC_GUARD_F];
        `DCDC_ADDR_COARSE: coarseSetR <= regWrData[`DCDC_COARSE_F];
        `DCDC_ADDR_FINE: fineSetR <= regWrData;
        `DCDC_ADDR_PHASE: phaseTgtR <= regWrData[`DCDC_PHASE_F];
        `DCDC_ADDR_FILT:
        begin
          bwR <= regWrData[`DCDC_BW_F];
          weightR <= regWrData[`DCDC_WEIGHT_F];
        end
        `DCDC_ADDR_READ: readReqR <= regWrData[`DCDC_READ_BIT];
        default: ;
      endcase
    end
  end

  // Phase comes from the analog detector, so it is resynchronised before filtering
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      phSync1R <= 5'h00;
      phSync2R <= 5'h00;
      filtR <= 8'h00;
    end
    else
    begin
      phSync1R <= phaseIn;
      phSync2R <= phSync1R;
      filtR <= filtR + filtStep[7:0];
    end
  end

  // Loop sequencer
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      stateR <= dcdc_pkg::ST_OFF;
      posR <= {`DCDC_COARSE_RST, `DCDC_FINE_RST};
      dirUpR <= 1'b0;
      settleCntR <= 8'h00;
      prevPhaseR <= 5'h00;
    end
    else if (!loopRun)
    begin
      stateR <= dcdc_pkg::ST_OFF;
      posR <= initPos;
    end
    else
    begin
      case (stateR)
        dcdc_pkg::ST_OFF:
        begin
          posR <= initPos;
          settleCntR <= SETTLE_LD;
          prevPhaseR <= phaseNow;
          dirUpR <= dirCode != `DCDC_DIR_DOWN;
          stateR <= (modeCode == `DCDC_MODE_TRK_ONLY) ? dcdc_pkg::ST_TRACK : dcdc_pkg::ST_SEARCH;
        end
        dcdc_pkg::ST_SEARCH:
        begin
          if (!tick)
            settleCntR <= settleCntR - 8'h01;
          else
          begin
            settleCntR <= SETTLE_LD;
            prevPhaseR <= phaseNow;
            if (searchHit)
              stateR <= (modeCode == `DCDC_MODE_SRCH_ONLY) ? dcdc_pkg::ST_HOLD : dcdc_pkg::ST_TRACK;
            else if (atEdge && dirCode == `DCDC_DIR_BOTH && dirUpR)
            begin
              dirUpR <= 1'b0;
              posR <= initPos;
            end
            else if (atEdge && ctrlR[`DCDC_CTRL_SERR])
            begin
              dirUpR <= dirCode != `DCDC_DIR_DOWN;
              posR <= initPos;
            end
            else if (atEdge)
              stateR <= dcdc_pkg::ST_FAIL;
            else
              posR <= step_pos(posR, dirUpR, 14'h0001, loBound, hiBound);
          end
        end
        dcdc_pkg::ST_TRACK:
        begin
          if (!tick)
            settleCntR <= settleCntR - 8'h01;
          else
          begin
            settleCntR <= SETTLE_LD;
            prevPhaseR <= phaseNow;
            if (trackErr && ctrlR[`DCDC_CTRL_TERR])
            begin
              posR <= initPos;
              dirUpR <= dirCode != `DCDC_DIR_DOWN;
              stateR <= (modeCode == `DCDC_MODE_TRK_ONLY) ? dcdc_pkg::ST_TRACK : dcdc_pkg::ST_SEARCH;
            end
            else if (!inWin)
              posR <= step_pos(posR, trackUp, 14'h0001 << weightR, 14'h0000, `DCDC_POS_MAX);
          end
        end
        dcdc_pkg::ST_HOLD: ;
        dcdc_pkg::ST_FAIL: ;
        default: stateR <= dcdc_pkg::ST_OFF;
      endcase
    end
  end

  // Status flags; an event in the cycle of a clear wins
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      lockedR <= 1'b0;
      lostR <= 1'b0;
      failR <= 1'b0;
    end
    else
    begin
      if (lockEvt)
        lockedR <= 1'b1;
      else if (trackErr || !loopRun || stateR == dcdc_pkg::ST_OFF)
        lockedR <= 1'b0;
      if (trackErr)
        lostR <= 1'b1;
      else if (lostClear)
        lostR <= 1'b0;
      if (failEvt)
        failR <= 1'b1;
      else if (!loopRun)
        failR <= 1'b0;
    end
  end

  // Snapshot taken only on the 0 to 1 write, so software sees a coherent set
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      coarseSnapR <= 6'h00;
      fineSnapR <= 8'h00;
      phaseSnapR <= 5'h00;
    end
    else if (snapEvt)
    begin
      coarseSnapR <= posR[13:8];
      fineSnapR <= posR[7:0];
      phaseSnapR <= phaseNow;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdDataR <= 8'h00;
    else if (regRdEn)
    begin
      case (regAddr)
        `DCDC_ADDR_CTRL: rdDataR <= ctrlR;
        `DCDC_ADDR_STATUS: rdDataR <= {5'h00, failR, lostR, lockedR};
        `DCDC_ADDR_GUARD: rdDataR <= {4'h0, guardR};
        `DCDC_ADDR_COARSE: rdDataR <= {2'b00, coarseSetR};
        `DCDC_ADDR_FINE: rdDataR <= fineSetR;
        `DCDC_ADDR_PHASE: rdDataR <= {3'h0, phaseTgtR};
        `DCDC_ADDR_FILT: rdDataR <= {3'h0, bwR, weightR};
        `DCDC_ADDR_READ: rdDataR <= {7'h00, readReqR};
        `DCDC_ADDR_RB_COARSE: rdDataR <= {2'b00, coarseSnapR};
        `DCDC_ADDR_RB_FINE: rdDataR <= fineSnapR;
        `DCDC_ADDR_RB_PHASE: rdDataR <= {3'h0, phaseSnapR};
        default: rdDataR <= 8'h00;
      endcase
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  static_follow_a: assert property (!loopRun |=> {coarseDelay, fineDelay} == $past(initPos))
    else $error("delay lines not at static setpoints");
  loop_start_a: assert property ((loopRun && stateR == dcdc_pkg::ST_OFF) |=>
    stateR == ($past(modeCode) == `DCDC_MODE_TRK_ONLY ? dcdc_pkg::ST_TRACK : dcdc_pkg::ST_SEARCH))
    else $error("loop started in wrong state");
  search_step_a: assert property ((searchHit == 1'b0 && tick && stateR == dcdc_pkg::ST_SEARCH && !atEdge) |=>
    posR == ($past(dirUpR) ? $past(posR) + 14'h0001 : $past(posR) - 14'h0001))
    else $error("search did not move one step");
  search_stop_a: assert property (failEvt |=> failR && stateR == dcdc_pkg::ST_FAIL)
    else $error("search error did not stop loop");
  search_retry_a: assert property ((searchErr && ctrlR[`DCDC_CTRL_SERR]) |=>
    posR == $past(initPos) && stateR == dcdc_pkg::ST_SEARCH && !failR)
    else $error("search error did not retry");
  lock_set_a: assert property (lockEvt |=> lockedR ##1 (lockedR || $past(trackErr) || !$past(loopRun)))
    else $error("lock flag not set");
  lost_set_a: assert property (trackErr |=> lostR && !lockedR)
    else $error("lost flag not set on loss");
  lost_hold_a: assert property ((lostR && !lostClear) |=> lostR)
    else $error("lost flag dropped without clear");
  snap_copy_a: assert property (snapEvt |=>
    {coarseSnapR, fineSnapR, phaseSnapR} == {$past(posR), $past(phaseNow)})
    else $error("snapshot did not copy live values");
  snap_hold_a: assert property (!snapEvt |=> $stable({coarseSnapR, fineSnapR, phaseSnapR}))
    else $error("snapshot changed without request edge");
  rb_reserved_a: assert property ((regRdEn && regAddr == `DCDC_ADDR_RB_COARSE) |=> regRdData[7:6] == 2'b00)
    else $error("coarse readback reserved bits set");
  pd_idle_a: assert property (loopPowerDown |-> dllPowerDown ##1 stateR == dcdc_pkg::ST_OFF)
    else $error("loop ran while powered down");

  lock_seen_c: cover property (searchHit ##[1:20] stateR == dcdc_pkg::ST_TRACK);
  lost_seen_c: cover property (trackErr);
  fail_seen_c: cover property (failEvt);
  snap_seen_c: cover property (snapEvt);
endmodule : dcdc_controller

//--- verif/dac_clock_dll_controller_tb.sv
`timescale 1ns/100ps
module dac_clock_dll_controller_tb;
  logic clk;
  logic reset;
  logic regWrEn;
  logic regRdEn;
  logic [11:0] regAddr;
  logic [7:0] regWrData;
  logic [7:0] regRdData;
  logic loopPowerDown;
  logic [4:0] phaseIn;
  logic [5:0] coarseDelay;
  logic [7:0] fineDelay;
  logic dllPowerDown;
  logic phHold;
  logic [4:0] phOff;
  logic [7:0] v;
  int miscompares;
  int checksDone;
  int cyc = 0;
  int mdl [int];

  dcdc_controller #(.SETTLE_NS(50)) dut_u (
    .clk(clk),
    .reset(reset),
    .regWrEn(regWrEn),
    .regRdEn(regRdEn),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regRdData(regRdData),
    .loopPowerDown(loopPowerDown),
    .phaseIn(phaseIn),
    .coarseDelay(coarseDelay),
    .fineDelay(fineDelay),
    .dllPowerDown(dllPowerDown)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Detector stand-in: phase rises with delay, so the loop sees a positive slope
  always @(posedge clk)
    phaseIn <= phHold ? 5'h00 : fineDelay[7:3] + phOff;

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      miscompares++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d miscompares %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checksDone++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  function automatic int msk(input logic [11:0] a);
    case (a)
      12'h091, 12'h095: return 'hff;
      12'h093: return 'h0f;
      12'h094: return 'h3f;
      12'h096, 12'h097: return 'h1f;
      12'h098: return 'h01;
      default: return 0;
    endcase
  endfunction : msk

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWrEn <= 1'b0;
    // Snapshot model assumes static delays, which is the only case it is used in
    if (a == 12'h098 && d[0] && (mdl[a] & 1) == 0)
    begin
      mdl['h099] = mdl['h094];
      mdl['h09a] = mdl['h095];
      mdl['h09b] = ((mdl['h095] >> 3) + phOff) & 31;
    end
    if (mdl.exists(a))
      mdl[a] = (mdl[a] & ~msk(a)) | (d & msk(a));
  endtask : wr

  task automatic rdv(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRdEn <= 1'b0;
    #1 d = regRdData;
  endtask : rdv

  task automatic rd(input logic [11:0] a);
    logic [7:0] d;
    rdv(a, d);
    chk(d, mdl.exists(a) ? 8'(mdl[a]) : 8'h00);
  endtask : rd

  task automatic waitSt(input int b);
    int n;
    n = 0;
    v = 8'h00;
    while (v[b] !== 1'b1 && n < 2000)
    begin
      rdv(12'h092, v);
      n++;
    end
  endtask : waitSt

  initial
  begin
    reset = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 12'h000;
    regWrData = 8'h00;
    loopPowerDown = 1'b1;
    phHold = 1'b0;
    phOff = 5'h00;
    miscompares = 0;
    checksDone = 0;
    for (int a = 'h091; a <= 'h09b; a++)
      mdl[a] = 0;
    mdl['h091] = 'hf0;
    mdl['h095] = 'h80;
    mdl['h096] = 'h08;
    void'($urandom(87));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({2'b00, coarseDelay}, 8'h00);
    chk(fineDelay, 8'h80);
    chk({7'h00, dllPowerDown}, 8'h01);
    for (int a = 'h091; a <= 'h09c; a++)
      rd(12'(a));
    for (int a = 'h091; a <= 'h09c; a++)
    begin
      v = 8'($urandom);
      if (a == 'h091 || a == 'h098)
        v[0] = 1'b0;
      wr(12'(a), v);
      rd(12'(a));
    end
    repeat (2) @(posedge clk);
    #1;
    chk({2'b00, coarseDelay}, 8'(mdl['h094]));
    chk(fineDelay, 8'(mdl['h095]));
    phOff <= 5'h03;
    wr(12'h097, 8'h00);
    wr(12'h095, 8'h5a);
    repeat (20) @(posedge clk);
    wr(12'h098, 8'h00);
    wr(12'h098, 8'h01);
    for (int a = 'h099; a <= 'h09b; a++)
      rd(12'(a));
    wr(12'h094, 8'h2c);
    wr(12'h098, 8'h01);
    rd(12'h099);
    wr(12'h091, 8'hf1);
    repeat (20) @(posedge clk);
    #1;
    chk({2'b00, coarseDelay}, 8'h2c);
    chk(fineDelay, 8'h5a);
    rd(12'h092);
    wr(12'h091, 8'hf0);
    loopPowerDown <= 1'b0;
    phOff <= 5'h00;
    @(posedge clk);
    #1;
    chk({7'h00, dllPowerDown}, 8'h00);
    wr(12'h093, 8'h00);
    wr(12'h094, 8'h00);
    wr(12'h095, 8'h20);
    wr(12'h096, 8'h08);
    wr(12'h091, 8'hf1);
    waitSt(0);
    chk(v, 8'h01);
    // A large offset pushes the phase error past the lost tolerance
    phOff <= 5'h0c;
    waitSt(1);
    chk({7'h00, v[1]}, 8'h01);
    wr(12'h092, 8'h02);
    rdv(12'h092, v);
    chk({7'h00, v[1]}, 8'h01);
    wr(12'h091, 8'hf0);
    wr(12'h092, 8'h00);
    rd(12'h092);
    chk({2'b00, coarseDelay}, 8'h00);
    chk(fineDelay, 8'h20);
    phHold <= 1'b1;
    wr(12'h093, 8'h0f);
    wr(12'h094, 8'h30);
    wr(12'h095, 8'h00);
    wr(12'h096, 8'h10);
    wr(12'h091, 8'had);
    waitSt(2);
    chk(v, 8'h04);
    chk({2'b00, coarseDelay}, 8'h30);
    chk(fineDelay, 8'hff);
    wr(12'h091, 8'hac);
    rd(12'h092);
    // Retry policy: a down-only search that meets the guard band restarts and never fails
    wr(12'h093, 8'h01);
    wr(12'h094, 8'h01);
    wr(12'h095, 8'h04);
    wr(12'h091, 8'he5);
    repeat (300) @(posedge clk);
    rd(12'h092);
    chk({7'h00, fineDelay <= 8'h04}, 8'h01);
    wr(12'h091, 8'he4);
    phHold <= 1'b0;
    phOff <= 5'h00;
    wr(12'h093, 8'h00);
    wr(12'h094, 8'h00);
    wr(12'h095, 8'h60);
    wr(12'h096, 8'h08);
    wr(12'h091, 8'h63);
    waitSt(0);
    chk(v, 8'h01);
    chk(fineDelay, 8'h4f);
    // Continue policy: after the loss the loop steps on from where it stood
    phOff <= 5'h04;
    waitSt(1);
    chk(fineDelay, 8'h4e);
    waitSt(0);
    chk(v, 8'h03);
    chk(fineDelay, 8'h2f);
    wr(12'h091, 8'h62);
    wr(12'h092, 8'h00);
    rd(12'h092);
    conclude();
  end
endmodule : dac_clock_dll_controller_tb
